// File: rsel_pkg.sv
package rsel_pkg;
  // selection-mode codes
  localparam logic [1:0] RSEL_MODE_MANUAL = 2'h0;
  localparam logic [1:0] RSEL_MODE_AUTO = 2'h1;
  localparam logic [1:0] RSEL_MODE_SHORT_HOLD = 2'h2;
  localparam logic [1:0] RSEL_MODE_AUTO_HOLD = 2'h3;
  localparam int RSEL_MODE_AUTO_BIT = 0;
  // reset values
  localparam logic [1:0] RSEL_MODE_RST = 2'h0;
  localparam logic [1:0] RSEL_REF_SELECT_RST = 2'h0;
  localparam logic [7:0] RSEL_HOLDOFF_COUNT_RST = 8'h80;
  localparam logic [1:0] RSEL_HOLDOFF_PRESCALE_RST = 2'h2;
  localparam logic [1:0] RSEL_REVAL_COUNT_RST = 2'h2;
  localparam logic RSEL_REVAL_PREDIV_RST = 1'b0;
  localparam logic [3:0] RSEL_POWERDOWN_RST = 4'h0;
  localparam logic RSEL_REF_LOSS_MASK_RST = 1'b0;
  // prescaler exponents for codes 00, 01, 10
  localparam int RSEL_PRESCALE_EXP0 = 15;
  localparam int RSEL_PRESCALE_EXP1 = 16;
  localparam int RSEL_PRESCALE_EXP2 = 17;
  localparam int RSEL_PRESCALE_W = 17;
  // valid-period counts, without and with pre-divider
  localparam logic [8:0] RSEL_REVAL_N0 = 9'h002;
  localparam logic [8:0] RSEL_REVAL_N1 = 9'h010;
  localparam logic [8:0] RSEL_REVAL_N2 = 9'h020;
  localparam logic [8:0] RSEL_REVAL_N3 = 9'h040;
  localparam int RSEL_PREDIV_SHIFT = 2;
  // missing-edge window in system clocks; a period with no edge reloads
  localparam logic [15:0] RSEL_EDGE_TIMEOUT_RST = 16'h0040;
endpackage

// File: rsel_mon_if.sv
interface rsel_mon_if;
  import rsel_pkg::*;
  logic [8:0] reload;
  logic [15:0] timeout;
  modport ctl (output reload, output timeout);
  modport mon (input reload, input timeout);
endinterface

// File: rsel_reval_mon.sv
// per-input activity loss detect and re-validation counter
module rsel_reval_mon
  import rsel_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic edge_seen,
  input wire logic powered_down,
  rsel_mon_if.mon cfg,
  output logic los_ff
);
  logic [8:0] reval_cnt_ff;
  logic [15:0] gap_cnt_ff;
  logic gap_hit;

  assign gap_hit = gap_cnt_ff >= cfg.timeout;

  // ****************
  // period watchdog
  // ****************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      gap_cnt_ff <= 16'h0000;
    else if (ce)
    begin
      if (edge_seen || gap_hit)
        gap_cnt_ff <= 16'h0000;
      else
        gap_cnt_ff <= gap_cnt_ff + 16'h0001;
    end
  end

  // ****************
  // los flag and re-validation
  // ****************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      los_ff <= 1'b1;
      reval_cnt_ff <= cfg.reload;
    end
    else if (ce)
    begin
      if (powered_down)
      begin
        los_ff <= 1'b1;
        reval_cnt_ff <= cfg.reload;
      end
      else if (gap_hit)
      begin
        los_ff <= 1'b1;
        reval_cnt_ff <= cfg.reload;
      end
      else if (los_ff && edge_seen)
      begin
        if (reval_cnt_ff <= 9'h001)
        begin
          los_ff <= 1'b0;
          reval_cnt_ff <= cfg.reload;
        end
        else
          reval_cnt_ff <= reval_cnt_ff - 9'h001;
      end
    end
  end

  AST_PD_FORCES_LOS: assert property (@(posedge clk) disable iff (!rst_b)
    ce && powered_down |=> los_ff)
    else $error("powered-down input not lost");
  AST_GAP_SETS_LOS: assert property (@(posedge clk) disable iff (!rst_b)
    ce && gap_hit |=> los_ff && reval_cnt_ff == $past(cfg.reload))
    else $error("missing edge did not reload");
endmodule

// File: rsel_top.sv
module rsel_top
  import rsel_pkg::*;
#(
  parameter int NUM_INPUTS = 4
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [NUM_INPUTS-1:0] ref_clk_in,
  input wire logic osc_pulse,
  input wire logic loop1_lock_loss_in,
  input wire logic [1:0] selection_mode_field,
  input wire logic [1:0] reference_select,
  input wire logic [7:0] holdoff_count,
  input wire logic [1:0] holdoff_prescale,
  input wire logic [1:0] revalidation_count,
  input wire logic revalidation_prediv,
  input wire logic [NUM_INPUTS-1:0] input_powerdown,
  input wire logic ref_loss_mask,
  input wire logic loop1_lock_loss_clear,
  output logic [1:0] selected_ref_ff,
  output logic [NUM_INPUTS-1:0] input_enable_ff,
  output logic [NUM_INPUTS-1:0] los_ff,
  output logic loop1_lock_loss_live_ff,
  output logic loop1_lock_loss_sticky_ff,
  output logic lock_ff,
  output logic failover_ff,
  output logic [7:0] holdoff_state_ff
);
  // selects and flags are sized for four inputs
  if (NUM_INPUTS != 4)
  begin : g_bad_inputs
    $error("rsel_top serves exactly four inputs");
  end

  typedef enum logic [1:0] {RSEL_IDLE, RSEL_HOLD, RSEL_SWITCH} rsel_hstate_t;

  rsel_mon_if mon_cfg();
  rsel_hstate_t hstate_ff;
  logic [NUM_INPUTS-1:0] ref_meta_ff;
  logic [NUM_INPUTS-1:0] ref_sync_ff;
  logic [NUM_INPUTS-1:0] ref_prev_ff;
  logic [NUM_INPUTS-1:0] edge_seen;
  logic osc_meta_ff;
  logic osc_sync_ff;
  logic osc_prev_ff;
  logic osc_tick;
  logic [RSEL_PRESCALE_W-1:0] presc_cnt_ff;
  logic [RSEL_PRESCALE_W-1:0] presc_last;
  logic holdoff_tick;
  logic [8:0] reval_base;
  logic [1:0] auto_ref_ff;
  logic [1:0] nxt_auto_ref;
  logic ref_lost;
  logic nxt_live;
  logic holdoff_zero;

  // ****************
  // input synchronisers
  // ****************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ref_meta_ff <= '0;
      ref_sync_ff <= '0;
      ref_prev_ff <= '0;
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end
    else if (ce)
    begin
      ref_meta_ff <= ref_clk_in;
      ref_sync_ff <= ref_meta_ff;
      ref_prev_ff <= ref_sync_ff;
      osc_meta_ff <= osc_pulse;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end

  assign edge_seen = ref_sync_ff & ~ref_prev_ff & ~input_powerdown;
  assign osc_tick = osc_sync_ff & ~osc_prev_ff;

  // ****************
  // re-validation monitors
  // ****************
  always_comb
  begin
    case (revalidation_count)
      2'h0: reval_base = RSEL_REVAL_N0;
      2'h1: reval_base = RSEL_REVAL_N1;
      2'h2: reval_base = RSEL_REVAL_N2;
      default: reval_base = RSEL_REVAL_N3;
    endcase
  end

  // pre-divider asks for four times as many valid periods
  always_comb
  begin
    if (revalidation_prediv)
      mon_cfg.reload = 9'(reval_base << RSEL_PREDIV_SHIFT);
    else
      mon_cfg.reload = reval_base;
  end

  assign mon_cfg.timeout = RSEL_EDGE_TIMEOUT_RST;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_mon
      rsel_reval_mon u_mon (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .edge_seen(edge_seen[gi]),
        .powered_down(input_powerdown[gi]),
        .cfg(mon_cfg.mon),
        .los_ff(los_ff[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      input_enable_ff <= '1;
    else if (ce)
      input_enable_ff <= ~input_powerdown;
  end

  // ****************
  // hold-off prescaler
  // ****************
  always_comb
  begin
    case (holdoff_prescale)
      2'h0: presc_last = RSEL_PRESCALE_W'((1 << RSEL_PRESCALE_EXP0) - 1);
      2'h1: presc_last = RSEL_PRESCALE_W'((1 << RSEL_PRESCALE_EXP1) - 1);
      default: presc_last = RSEL_PRESCALE_W'((1 << RSEL_PRESCALE_EXP2) - 1);
    endcase
  end

  assign holdoff_tick = osc_tick && presc_cnt_ff >= presc_last;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      presc_cnt_ff <= '0;
    else if (ce)
    begin
      if (hstate_ff != RSEL_HOLD)
        presc_cnt_ff <= '0;
      else if (holdoff_tick)
        presc_cnt_ff <= '0;
      else if (osc_tick)
        presc_cnt_ff <= presc_cnt_ff + RSEL_PRESCALE_W'(1);
    end
  end

  // ****************
  // hold-off state machine
  // ****************
  assign ref_lost = los_ff[auto_ref_ff];
  assign holdoff_zero = holdoff_tick && holdoff_state_ff <= 8'h01;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      hstate_ff <= RSEL_IDLE;
      holdoff_state_ff <= RSEL_HOLDOFF_COUNT_RST;
      failover_ff <= 1'b0;
    end
    else if (ce)
    begin
      failover_ff <= 1'b0;
      if (selection_mode_field != RSEL_MODE_AUTO_HOLD)
      begin
        hstate_ff <= RSEL_IDLE;
        holdoff_state_ff <= holdoff_count;
      end
      else
      begin
        case (hstate_ff)
          RSEL_IDLE:
          begin
            holdoff_state_ff <= holdoff_count;
            if (ref_lost)
              hstate_ff <= RSEL_HOLD;
          end
          RSEL_HOLD:
          begin
            if (holdoff_zero)
            begin
              holdoff_state_ff <= holdoff_count;
              hstate_ff <= RSEL_SWITCH;
            end
            else if (holdoff_tick)
              holdoff_state_ff <= holdoff_state_ff - 8'h01;
          end
          RSEL_SWITCH:
          begin
            failover_ff <= 1'b1;
            hstate_ff <= RSEL_IDLE;
          end
          default: hstate_ff <= RSEL_IDLE;
        endcase
      end
    end
  end

  // ****************
  // automatic pick: lowest-numbered valid input
  // ****************
  always_comb
  begin
    nxt_auto_ref = auto_ref_ff;
    for (int i = NUM_INPUTS - 1; i >= 0; i--)
    begin
      if (!los_ff[i])
        nxt_auto_ref = 2'(i);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      auto_ref_ff <= RSEL_REF_SELECT_RST;
    else if (ce)
    begin
      if (selection_mode_field == RSEL_MODE_AUTO && los_ff[auto_ref_ff])
        auto_ref_ff <= nxt_auto_ref;
      else if (selection_mode_field == RSEL_MODE_AUTO_HOLD && hstate_ff == RSEL_SWITCH)
        auto_ref_ff <= nxt_auto_ref;
      else if (!selection_mode_field[RSEL_MODE_AUTO_BIT])
        auto_ref_ff <= reference_select;
    end
  end

  // ****************
  // reference mux
  // ****************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      selected_ref_ff <= RSEL_REF_SELECT_RST;
    else if (ce)
    begin
      if (selection_mode_field[RSEL_MODE_AUTO_BIT])
        selected_ref_ff <= auto_ref_ff;
      else
        selected_ref_ff <= reference_select;
    end
  end

  AST_MANUAL_ROUTE: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !selection_mode_field[0] |=> selected_ref_ff == $past(reference_select))
    else $error("manual select not routed");
  AST_AUTO_IGNORES_SEL: assert property (@(posedge clk) disable iff (!rst_b)
    ce && selection_mode_field[0] |=> selected_ref_ff == $past(auto_ref_ff))
    else $error("auto mode followed select field");

  // ****************
  // lock-loss indications
  // ****************
  assign nxt_live = loop1_lock_loss_in || (!ref_loss_mask && los_ff[selected_ref_ff]);

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      loop1_lock_loss_live_ff <= 1'b0;
      loop1_lock_loss_sticky_ff <= 1'b0;
      lock_ff <= 1'b0;
    end
    else if (ce)
    begin
      loop1_lock_loss_live_ff <= nxt_live;
      if (nxt_live)
        loop1_lock_loss_sticky_ff <= 1'b1;
      else if (loop1_lock_loss_clear)
        loop1_lock_loss_sticky_ff <= 1'b0;
      lock_ff <= !nxt_live;
    end
  end

  AST_MASK_BLOCKS_LOR: assert property (@(posedge clk) disable iff (!rst_b)
    ce && ref_loss_mask && !loop1_lock_loss_in |=> lock_ff && !loop1_lock_loss_live_ff)
    else $error("masked reference loss reached lock");
  AST_UNMASKED_LOR: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !ref_loss_mask && los_ff[selected_ref_ff] |=> loop1_lock_loss_live_ff && !lock_ff)
    else $error("reference loss not flagged");
  AST_STICKY_HOLDS: assert property (@(posedge clk) disable iff (!rst_b)
    ce && nxt_live |=> loop1_lock_loss_sticky_ff)
    else $error("sticky flag lost");
  AST_HOLDOFF_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    ce && selection_mode_field != 2'h3 |=> holdoff_state_ff == $past(holdoff_count) && !failover_ff)
    else $error("hold-off ran outside holdover mode");
  AST_HOLDOFF_RELOAD: assert property (@(posedge clk) disable iff (!rst_b)
    ce && hstate_ff == RSEL_HOLD && holdoff_zero && selection_mode_field == 2'h3
    |=> holdoff_state_ff == $past(holdoff_count) ##1 failover_ff)
    else $error("no reload and switch at zero");

  // ****************
  // further rule checks
  // ****************
  AST_LOCK_LOSS_IN: assert property (@(posedge clk) disable iff (!rst_b)
    ce && loop1_lock_loss_in |=> loop1_lock_loss_live_ff && !lock_ff)
    else $error("loop lock loss not flagged");
  AST_SWITCH_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
    ce && hstate_ff == RSEL_SWITCH |=> failover_ff)
    else $error("fail-over switch not signalled");
  AST_PRESCALE_SHORT: assert property (@(posedge clk) disable iff (!rst_b)
    holdoff_tick && holdoff_prescale == 2'h0 |-> presc_cnt_ff == 17'h07FFF)
    else $error("short prescaler tick misplaced");
  AST_PREDIV_RELOAD: assert property (@(posedge clk) disable iff (!rst_b)
    revalidation_count == 2'h3 && revalidation_prediv |-> mon_cfg.reload == 9'h100)
    else $error("pre-divided re-validation count wrong");
endmodule

// File: rsel_ref_model.sv
// far-side model: four reference clocks and the oscillator-loop output
module rsel_ref_model
#(
  parameter int HALF = 4
)
(
  input wire logic clk,
  input wire logic [3:0] run,
  output logic [3:0] ref_clk,
  output logic osc
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;

  initial
  begin
    cnt = 0;
    osc = 1'b0;
    ref_clk = 4'h0;
  end

  // a stopped input parks low, as a dead clock line would
  always
  begin
    @(posedge clk);
    // move after the bench has driven, so run is read settled
    #2;
    osc = ~osc;
    cnt = cnt + 1;
    for (int i = 0; i < 4; i++)
      ref_clk[i] = (run[i] && cnt % HALF == 0) ? ~ref_clk[i] : ref_clk[i] & run[i];
  end
endmodule

// File: ref_input_selection_bench.sv
module ref_input_selection_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, ce, osc, lli, rdiv, mask, lclr, live, sticky, lock, fo;
  logic [1:0] mode, sel, hpre, rcnt, selr;
  logic [3:0] run, refc, pd, en, los;
  logic [7:0] hcnt, hst, h;
  int errors = 0;
  int compares = 0;

  rsel_ref_model model (.clk(clk), .run(run), .ref_clk(refc), .osc(osc));

  rsel_top dut (.clk(clk), .rst_b(rst_b), .ce(ce), .ref_clk_in(refc), .osc_pulse(osc),
    .loop1_lock_loss_in(lli), .selection_mode_field(mode), .reference_select(sel),
    .holdoff_count(hcnt), .holdoff_prescale(hpre), .revalidation_count(rcnt),
    .revalidation_prediv(rdiv), .input_powerdown(pd), .ref_loss_mask(mask),
    .loop1_lock_loss_clear(lclr), .selected_ref_ff(selr), .input_enable_ff(en),
    .los_ff(los), .loop1_lock_loss_live_ff(live), .loop1_lock_loss_sticky_ff(sticky),
    .lock_ff(lock), .failover_ff(fo), .holdoff_state_ff(hst));

  // ***************************************************
  // helpers
  // ***************************************************
  task automatic check(logic [8:0] seen, logic [8:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_los(int i, logic v, int lim, output int c);
    c = 0;
    while (los[i] !== v && c < lim)
    begin
      cyc(1);
      c++;
    end
    check(9'(los[i]), 9'(v));
  endtask

  function automatic int reval_n(logic [1:0] c, logic d);
    int n;
    n = (c == 2'h0) ? 2 : (c == 2'h1) ? 16 : (c == 2'h2) ? 32 : 64;
    return d ? n * 4 : n;
  endfunction

  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #900000;
    errors++;
    summarize();
  end

  // ***************************************************
  // tests
  // ***************************************************
  initial
  begin
    int c;
    int n;
    void'($urandom(32'h8F1B10C4));
    rst_b = 1'b0;
    ce = 1'b1;
    run = 4'hF;
    lli = 1'b0;
    mode = 2'h0;
    sel = 2'h0;
    hcnt = 8'h80;
    hpre = 2'h2;
    rcnt = 2'h2;
    rdiv = 1'b0;
    pd = 4'h0;
    mask = 1'b0;
    lclr = 1'b0;
    cyc(6);
    check(9'(hst), 9'h080);
    check(9'(selr), 9'h000);
    check(9'({en, los}), 9'h0FF);
    check(9'({live, sticky, lock, fo}), 9'h000);
    rst_b = 1'b1;
    for (int i = 0; i < 4; i++)
      wait_los(i, 1'b0, 600, c);
    // manual modes follow the select field
    for (int m = 0; m < 2; m++)
      for (int s = 0; s < 4; s++)
      begin
        mode = 2'(m * 2);
        sel = 2'(s);
        cyc(2);
        check(9'(selr), 9'(s));
      end
    // clock enable low freezes the selection
    ce = 1'b0;
    sel = 2'h1;
    cyc(3);
    check(9'(selr), 9'h003);
    ce = 1'b1;
    sel = 2'h0;
    cyc(2);
    check(9'(selr), 9'h000);
    // automatic mode ignores the select field
    mode = 2'h1;
    repeat (4)
    begin
      sel = 2'($urandom);
      cyc(2);
      check(9'(selr), 9'h000);
    end
    run[0] = 1'b0;
    wait_los(0, 1'b1, 80, c);
    cyc(3);
    check(9'(selr), 9'h001);
    run[0] = 1'b1;
    wait_los(0, 1'b0, 600, c);
    // power-down acts in every mode; here it is tried in manual mode
    mode = 2'h0;
    pd = 4'($urandom_range(1, 15));
    cyc(3);
    check(9'(en), {5'h00, ~pd});
    check(9'(los & pd), 9'(pd));
    pd = 4'h0;
    for (int i = 0; i < 4; i++)
      wait_los(i, 1'b0, 600, c);
    // lock flags with and without the reference-loss mask
    sel = 2'h0;
    cyc(2);
    run[0] = 1'b0;
    wait_los(0, 1'b1, 80, c);
    cyc(2);
    check(9'({live, sticky, lock}), 9'h006);
    mask = 1'b1;
    cyc(3);
    check(9'({live, sticky, lock}), 9'h003);
    lclr = 1'b1;
    cyc(1);
    lclr = 1'b0;
    cyc(2);
    check(9'(sticky), 9'h000);
    lli = 1'b1;
    cyc(3);
    check(9'({live, sticky, lock}), 9'h006);
    lli = 1'b0;
    mask = 1'b0;
    run[0] = 1'b1;
    wait_los(0, 1'b0, 600, c);
    cyc(3);
    check(9'({live, lock}), 9'h001);
    // re-validation period counts; case k == 6 drops edges midway
    for (int k = 0; k < 8; k++)
    begin
      rcnt = 2'(k);
      rdiv = (k == 4 || k == 5 || k == 7);
      n = reval_n(rcnt, rdiv);
      run[1] = 1'b0;
      wait_los(1, 1'b1, 80, c);
      run[1] = 1'b1;
      if (k == 6)
      begin
        cyc(48);
        run[1] = 1'b0;
        cyc(80);
        run[1] = 1'b1;
      end
      wait_los(1, 1'b0, 2200, c);
      check(9'(c >= n * 8 - 10 && c <= n * 8 + 10), 9'h001);
    end
    // hold-off countdown and fail-over
    rcnt = 2'h2;
    rdiv = 1'b0;
    hcnt = 8'h01;
    hpre = 2'h0;
    run[0] = 1'b0;
    wait_los(0, 1'b1, 80, c);
    h = hst;
    cyc(200);
    check(9'(hst), 9'(h));
    mode = 2'h3;
    c = 0;
    while (fo !== 1'b1 && c < 66000)
    begin
      cyc(1);
      c++;
    end
    check(9'(fo), 9'h001);
    check(9'(c >= 65520 && c <= 65560), 9'h001);
    check(9'(hst), 9'h001);
    cyc(1);
    check(9'({fo, selr}), 9'h001);
    summarize();
  end
endmodule
